// *** include/flash_host_pkg.sv ***
// Purpose: shared constants for the parallel flash host controller
// Assumes: 200 MHz system clock, 32-bit APB register bus
// Notes: flash command codes, status bit positions, register map, pin timing
package flash_host_pkg;

  // flash command codes
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;

  // operation_status bit positions
  localparam int SR_READY = 7;
  localparam int SR_SUSPEND = 6;
  localparam int SR_ERASE_FAIL = 5;
  localparam int SR_PROG_FAIL = 4;
  localparam int SR_SUPPLY = 3;
  localparam logic [7:0] SR_DEFINED_MASK = 8'hF8;
  localparam logic [7:0] SR_ERROR_MASK = 8'h38;

  // register byte offsets
  localparam logic [11:0] REG_CMD = 12'h000;
  localparam logic [11:0] REG_CONFIG = 12'h004;
  localparam logic [11:0] REG_ADDR = 12'h008;
  localparam logic [11:0] REG_WDATA = 12'h00C;
  localparam logic [11:0] REG_RDATA = 12'h010;
  localparam logic [11:0] REG_STATUS = 12'h014;

  // host operation codes in REG_CMD
  localparam logic [3:0] OP_READ_DATA = 4'h0;
  localparam logic [3:0] OP_READ_ID = 4'h1;
  localparam logic [3:0] OP_READ_STATUS = 4'h2;
  localparam logic [3:0] OP_CLEAR_STATUS = 4'h3;
  localparam logic [3:0] OP_ERASE = 4'h4;
  localparam logic [3:0] OP_PROGRAM = 4'h5;
  localparam logic [3:0] OP_SUSPEND = 4'h6;
  localparam logic [3:0] OP_RESUME = 4'h7;
  localparam logic [3:0] OP_ARRAY_MODE = 4'h8;

  // field positions and reset values
  localparam int CMD_NOWAIT_BIT = 4;
  localparam int CFG_WORD_BIT = 0;
  localparam int CFG_UNLOCK_BIT = 1;
  localparam int CFG_PDOWN_BIT = 2;
  localparam logic [2:0] CFG_RESET = 3'h1;
  localparam int STAT_BUSY_BIT = 8;
  localparam int STAT_SUSP_BIT = 9;
  localparam int STAT_REFUSED_BIT = 10;
  localparam int STAT_ERR_BIT = 11;
  localparam int STAT_MODE_LSB = 12;

  typedef enum logic [1:0] {MODE_ARRAY, MODE_ID, MODE_STATUS} flash_mode_type;

  // pin timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int T_SETUP_NS = 10;
  localparam int T_WRITE_PULSE_NS = 50;
  localparam int T_READ_ACCESS_NS = 90;
  localparam int T_HOLD_NS = 10;
  localparam int T_RECOVER_NS = 20;
  localparam int SYNC_STAGES = 3;
  localparam logic [7:0] SETUP_CYC = 8'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] WRITE_CYC =
    8'((T_WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] READ_CYC =
    8'((T_READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES + 1);
  localparam logic [7:0] HOLD_CYC = 8'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] RECOVER_CYC = 8'((T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage

// *** include/flash_cycle_if.sv ***
// Purpose: one flash bus cycle request between sequencer and pin engine
// Assumes: single clock domain
// Notes: req holds until done pulses
`timescale 1ns/1ps
interface flash_cycle_if;
  logic req;
  logic write;
  logic [19:0] addr;
  logic [15:0] wdata;
  logic word_mode;
  logic done;
  logic [15:0] rdata;

  modport seq (output req, output write, output addr, output wdata, output word_mode,
    input done, input rdata);
  modport eng (input req, input write, input addr, input wdata, input word_mode,
    output done, output rdata);
endinterface

// *** design/flash_pin_cycle.sv ***
// Purpose: drives one flash read or write cycle on the strobe pins
// Assumes: request held until done
// Notes: read data passes a three-stage synchroniser
`timescale 1ns/1ps
module flash_pin_cycle
  import flash_host_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_clk_en,
  // request
  flash_cycle_if.eng cyc,
  // flash pins
  output logic o_ce_n,
  output logic o_we_n,
  output logic o_oe_n,
  output logic [18:0] o_addr,
  output logic [15:0] o_dq,
  output logic [15:0] o_dq_oe,
  input wire logic [15:0] i_dq
);

  typedef enum {E_IDLE, E_SETUP, E_STROBE, E_HOLD, E_RECOVER} eng_state_type;

  eng_state_type state, next_state;
  logic [7:0] cnt, next_cnt;
  logic ce_n, next_ce_n, we_n, next_we_n, oe_n, next_oe_n;
  logic [18:0] addr, next_addr;
  logic [15:0] dq, next_dq, dq_oe, next_dq_oe, rdata, next_rdata;
  logic done, next_done;
  logic [15:0] dq_s1, dq_s2, dq_s3, dq_stable, next_dq_stable;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_ce_n = ce_n;
    next_we_n = we_n;
    next_oe_n = oe_n;
    next_addr = addr;
    next_dq = dq;
    next_dq_oe = dq_oe;
    next_rdata = rdata;
    next_done = 1'b0;
    // a bit counts only once the later two stages agree
    next_dq_stable = (dq_s2 & dq_s3) | (dq_stable & (dq_s2 | dq_s3));
    case (state)
      E_IDLE: begin
        if (cyc.req && !done) begin
          next_state = E_SETUP;
          next_cnt = SETUP_CYC;
          next_ce_n = 1'b0;
          next_addr = cyc.word_mode ? cyc.addr[18:0] : cyc.addr[19:1];
          if (cyc.word_mode) begin
            next_dq = cyc.wdata;
            next_dq_oe = {16{cyc.write}};
          end else begin
            next_dq = {cyc.addr[0], 7'h00, cyc.wdata[7:0]};
            next_dq_oe = {1'b1, 7'h00, {8{cyc.write}}};
          end
        end
      end
      E_SETUP: begin
        if (cnt <= 8'h01) begin
          next_state = E_STROBE;
          next_cnt = cyc.write ? WRITE_CYC : READ_CYC;
          next_we_n = ~cyc.write;
          next_oe_n = cyc.write;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      E_STROBE: begin
        if (cnt <= 8'h01) begin
          next_state = E_HOLD;
          next_cnt = HOLD_CYC;
          // write-enable rises first, so it is the latching edge
          next_we_n = 1'b1;
          next_oe_n = 1'b1;
          if (!cyc.write) begin
            next_rdata = dq_stable;
          end
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      E_HOLD: begin
        if (cnt <= 8'h01) begin
          next_state = E_RECOVER;
          next_cnt = RECOVER_CYC;
          next_ce_n = 1'b1;
          next_dq_oe = 16'h0000;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      E_RECOVER: begin
        if (cnt <= 8'h01) begin
          next_state = E_IDLE;
          next_done = 1'b1;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      default: next_state = E_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= E_IDLE;
      cnt <= 8'h00;
      ce_n <= 1'b1;
      we_n <= 1'b1;
      oe_n <= 1'b1;
      addr <= 19'h00000;
      dq <= 16'h0000;
      dq_oe <= 16'h0000;
      rdata <= 16'h0000;
      done <= 1'b0;
      dq_s1 <= 16'h0000;
      dq_s2 <= 16'h0000;
      dq_s3 <= 16'h0000;
      dq_stable <= 16'h0000;
    end else if (i_clk_en) begin
      state <= next_state;
      cnt <= next_cnt;
      ce_n <= next_ce_n;
      we_n <= next_we_n;
      oe_n <= next_oe_n;
      addr <= next_addr;
      dq <= next_dq;
      dq_oe <= next_dq_oe;
      rdata <= next_rdata;
      done <= next_done;
      dq_s1 <= i_dq;
      dq_s2 <= dq_s1;
      dq_s3 <= dq_s2;
      dq_stable <= next_dq_stable;
    end
  end

  assign o_ce_n = ce_n;
  assign o_we_n = we_n;
  assign o_oe_n = oe_n;
  assign o_addr = addr;
  assign o_dq = dq;
  assign o_dq_oe = dq_oe;
  assign cyc.done = done;
  assign cyc.rdata = rdata;

endmodule

// *** design/flash_host_ctrl.sv ***
// Purpose: APB-controlled host sequencer for an asynchronous parallel flash
// Assumes: flash command set with two-cycle program and erase, 200 MHz clock
// Notes: one APB wait state per access; operations run one at a time
//
// Contract
// - program cycle: output enable high, chip and write enable low, supply on.
// - boot block program needs write protect high or unlock voltage on reset.
// - program setup command goes in the cycle right before each program.
// - read array command needed after other commands, not after reset.
// - erase needs setup then confirm; no confirm means no erase.
// - never issue reserved or undefined command codes.
// - command cycle strobes; command on low eight pins only.
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module flash_host_ctrl
  import flash_host_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_clk_en,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // flash pins
  output logic o_flash_ce_n,
  output logic o_flash_we_n,
  output logic o_flash_oe_n,
  output logic [18:0] o_flash_addr,
  output logic [15:0] o_flash_dq,
  output logic [15:0] o_flash_dq_oe,
  input wire logic [15:0] i_flash_dq,
  output logic o_width_select_n,
  output logic o_program_supply_en,
  output logic o_write_protect_n,
  output logic o_reset_powerdown_n
);

  typedef enum {S_IDLE, S_CMD1, S_CMD2, S_READ, S_POLL} seq_state_type;

  flash_cycle_if cyc ();

  seq_state_type state, next_state;
  flash_mode_type mode, next_mode;
  logic [3:0] op, next_op;
  logic nowait, next_nowait;
  logic [2:0] cfg, next_cfg;
  logic [19:0] addr, next_addr;
  logic [15:0] wdata, next_wdata, rdata, next_rdata;
  logic [7:0] fstat, next_fstat, cmd1, next_cmd1;
  logic suspended, next_suspended, refused, next_refused, vpp, next_vpp;
  logic req, next_req, req_wr, next_req_wr;
  logic [15:0] req_data, next_req_data;
  logic [31:0] prdata, next_prdata;
  logic pready, next_pready, pslverr, next_pslverr;
  logic access, commit, mapped, accept, legal;
  logic [7:0] rd_status;
  logic [31:0] status_word;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    access = i_psel & i_penable;
    commit = access & pready & ~pslverr;
    mapped = (i_paddr == REG_CMD) | (i_paddr == REG_CONFIG) | (i_paddr == REG_ADDR) |
             (i_paddr == REG_WDATA) | (i_paddr == REG_RDATA) | (i_paddr == REG_STATUS);
    rd_status = cyc.rdata[7:0] & SR_DEFINED_MASK;
    status_word = 32'h00000000;
    status_word[7:0] = fstat;
    status_word[STAT_BUSY_BIT] = (state != S_IDLE);
    status_word[STAT_SUSP_BIT] = suspended;
    status_word[STAT_REFUSED_BIT] = refused;
    status_word[STAT_ERR_BIT] = |(fstat & SR_ERROR_MASK);
    status_word[STAT_MODE_LSB +: 2] = mode;
    next_state = state;
    next_mode = mode;
    next_op = op;
    next_nowait = nowait;
    next_cfg = cfg;
    next_addr = addr;
    next_wdata = wdata;
    next_rdata = rdata;
    next_fstat = fstat;
    next_cmd1 = cmd1;
    next_suspended = suspended;
    next_refused = refused;
    next_vpp = vpp;
    next_req = req;
    next_req_wr = req_wr;
    next_req_data = req_data;
    next_prdata = prdata;
    next_pslverr = pslverr;
    // one wait state, so every answer comes from a flip-flop
    next_pready = access & ~pready;
    if (access && !pready) begin
      next_pslverr = ~mapped;
      case (i_paddr)
        REG_CMD: next_prdata = {27'h0000000, nowait, op};
        REG_CONFIG: next_prdata = {29'h00000000, cfg};
        REG_ADDR: next_prdata = {12'h000, addr};
        REG_WDATA: next_prdata = {16'h0000, wdata};
        REG_RDATA: next_prdata = {16'h0000, rdata};
        REG_STATUS: next_prdata = status_word;
        default: next_prdata = 32'h00000000;
      endcase
    end
    if (commit && i_pwrite) begin
      if (i_paddr == REG_CONFIG) next_cfg = i_pwdata[2:0];
      if (i_paddr == REG_ADDR) next_addr = i_pwdata[19:0];
      if (i_paddr == REG_WDATA) next_wdata = i_pwdata[15:0];
      if (i_paddr == REG_STATUS && i_pwdata[STAT_REFUSED_BIT]) next_refused = 1'b0;
    end
    // only defined operations map to defined command codes
    legal = (i_pwdata[3:0] <= OP_ARRAY_MODE);
    if (suspended && !(i_pwdata[3:0] == OP_READ_DATA || i_pwdata[3:0] == OP_READ_STATUS ||
        i_pwdata[3:0] == OP_RESUME || i_pwdata[3:0] == OP_ARRAY_MODE)) begin
      legal = 1'b0;
    end
    if ((i_pwdata[3:0] == OP_ERASE || i_pwdata[3:0] == OP_PROGRAM) && fstat[SR_SUPPLY]) begin
      legal = 1'b0;
    end
    if (i_pwdata[3:0] == OP_RESUME && !suspended) legal = 1'b0;
    accept = commit & i_pwrite & (i_paddr == REG_CMD);
    if (accept && (state != S_IDLE || !legal)) begin
      // busy flash ignores commands, so a late order is refused here
      next_refused = 1'b1;
    end else if (accept) begin
      next_op = i_pwdata[3:0];
      next_nowait = i_pwdata[CMD_NOWAIT_BIT];
      next_state = S_CMD1;
      case (i_pwdata[3:0])
        OP_READ_DATA: begin
          next_cmd1 = CMD_READ_ARRAY;
          if (mode == MODE_ARRAY) next_state = S_READ;
        end
        OP_READ_ID: next_cmd1 = CMD_READ_ID;
        OP_READ_STATUS: next_cmd1 = CMD_READ_STATUS;
        OP_CLEAR_STATUS: next_cmd1 = CMD_CLEAR_STATUS;
        OP_ERASE: next_cmd1 = CMD_ERASE_SETUP;
        OP_PROGRAM: next_cmd1 = CMD_PROG_SETUP;
        OP_SUSPEND: next_cmd1 = CMD_SUSPEND;
        OP_RESUME: next_cmd1 = CMD_CONFIRM;
        default: next_cmd1 = CMD_READ_ARRAY;
      endcase
      if (i_pwdata[3:0] == OP_ERASE || i_pwdata[3:0] == OP_PROGRAM ||
          i_pwdata[3:0] == OP_RESUME) begin
        next_vpp = 1'b1;
      end
    end
    // request issue and completion for the pin engine
    if (state != S_IDLE && !req && !cyc.done) begin
      next_req = 1'b1;
      next_req_wr = (state == S_CMD1) || (state == S_CMD2);
      if (state == S_CMD2) begin
        // program data can only pull bits low; erase is the only way back up
        next_req_data = (op == OP_PROGRAM) ? wdata : {8'h00, CMD_CONFIRM};
      end else begin
        next_req_data = {8'h00, cmd1};
      end
    end
    if (cyc.done) begin
      next_req = 1'b0;
      case (state)
        S_CMD1: begin
          case (cmd1)
            CMD_READ_ARRAY: next_mode = MODE_ARRAY;
            CMD_READ_ID: next_mode = MODE_ID;
            default: next_mode = MODE_STATUS;
          endcase
          if (cmd1 == CMD_CLEAR_STATUS) begin
            next_fstat = fstat & ~SR_ERROR_MASK;
          end
          if (op == OP_RESUME) next_suspended = 1'b0;
          case (op)
            OP_ERASE, OP_PROGRAM: next_state = S_CMD2;
            OP_READ_DATA, OP_READ_ID, OP_READ_STATUS: next_state = S_READ;
            OP_SUSPEND: next_state = S_POLL;
            OP_RESUME: next_state = nowait ? S_IDLE : S_POLL;
            default: next_state = S_IDLE;
          endcase
        end
        S_CMD2: begin
          next_mode = MODE_STATUS;
          next_state = nowait ? S_IDLE : S_POLL;
        end
        S_READ: begin
          next_rdata = cyc.rdata;
          next_state = S_IDLE;
          if (op == OP_READ_STATUS) begin
            next_fstat = rd_status;
            if (rd_status[SR_READY]) next_vpp = 1'b0;
            next_suspended = rd_status[SR_SUSPEND];
          end
        end
        S_POLL: begin
          // each poll is a fresh strobe, so the flash shows current status
          next_fstat = rd_status;
          next_rdata = cyc.rdata;
          next_suspended = rd_status[SR_SUSPEND];
          if (rd_status[SR_READY]) begin
            next_state = S_IDLE;
            next_vpp = 1'b0;
          end
        end
        default: next_state = S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= S_IDLE;
      mode <= MODE_ARRAY;
      op <= OP_READ_DATA;
      nowait <= 1'b0;
      cfg <= CFG_RESET;
      addr <= 20'h00000;
      wdata <= 16'h0000;
      rdata <= 16'h0000;
      fstat <= 8'h00;
      cmd1 <= CMD_READ_ARRAY;
      suspended <= 1'b0;
      refused <= 1'b0;
      vpp <= 1'b0;
      req <= 1'b0;
      req_wr <= 1'b0;
      req_data <= 16'h0000;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (i_clk_en) begin
      state <= next_state;
      mode <= next_mode;
      op <= next_op;
      nowait <= next_nowait;
      cfg <= next_cfg;
      addr <= next_addr;
      wdata <= next_wdata;
      rdata <= next_rdata;
      fstat <= next_fstat;
      cmd1 <= next_cmd1;
      suspended <= next_suspended;
      refused <= next_refused;
      vpp <= next_vpp;
      req <= next_req;
      req_wr <= next_req_wr;
      req_data <= next_req_data;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  assign cyc.req = req;
  assign cyc.write = req_wr;
  assign cyc.addr = addr;
  assign cyc.wdata = req_data;
  assign cyc.word_mode = cfg[CFG_WORD_BIT];

  flash_pin_cycle u_pin (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_clk_en(i_clk_en),
    .cyc(cyc),
    .o_ce_n(o_flash_ce_n),
    .o_we_n(o_flash_we_n),
    .o_oe_n(o_flash_oe_n),
    .o_addr(o_flash_addr),
    .o_dq(o_flash_dq),
    .o_dq_oe(o_flash_dq_oe),
    .i_dq(i_flash_dq)
  );

  assign o_prdata = prdata;
  assign o_pready = pready;
  assign o_pslverr = pslverr;
  assign o_width_select_n = cfg[CFG_WORD_BIT];
  assign o_program_supply_en = vpp;
  assign o_write_protect_n = cfg[CFG_UNLOCK_BIT];
  // power-down also wipes the flash error flags
  assign o_reset_powerdown_n = ~cfg[CFG_PDOWN_BIT];

endmodule

// *** verif/flash_host_ctrl_asserts.sv ***
// Purpose: bus and flash pin timing checks for the flash host controller
// Assumes: one clock domain, registered outputs
// Notes: bound to every controller instance
`timescale 1ns/1ps
module flash_host_ctrl_asserts
  import flash_host_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // apb
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  // flash pins
  input wire logic o_flash_ce_n,
  input wire logic o_flash_we_n,
  input wire logic o_flash_oe_n,
  input wire logic [18:0] o_flash_addr,
  input wire logic [15:0] o_flash_dq,
  input wire logic [15:0] o_flash_dq_oe,
  input wire logic o_program_supply_en
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  a_write_strobes: assert property (!o_flash_we_n |-> o_flash_oe_n && !o_flash_ce_n)
    else $error("write strobe with bad chip or output enable");
  a_read_no_drive: assert property (!o_flash_oe_n |-> o_flash_dq_oe[14:0] == 15'h0000)
    else $error("data driven during a read");
  a_apb_wait: assert property (i_psel && i_penable && !$past(i_penable) |-> !o_pready ##1 o_pready)
    else $error("ready not in second access cycle");
  a_pready_pulse: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  a_ce_setup: assert property ($fell(o_flash_ce_n) |-> o_flash_we_n ##1 o_flash_we_n)
    else $error("write enable without chip enable setup");
  a_we_pulse: assert property ($fell(o_flash_we_n) |=> !o_flash_we_n [*8])
    else $error("write pulse too short");
  a_latch_hold: assert property ($rose(o_flash_we_n)
    |=> $stable(o_flash_addr) && !o_flash_ce_n)
    else $error("address not held after latch edge");
  a_dq_steady: assert property (!o_flash_we_n && !$past(o_flash_we_n)
    |-> $stable(o_flash_dq))
    else $error("data moved during write pulse");
  a_confirm_supply: assert property (!o_flash_we_n && o_flash_dq[7:0] == CMD_CONFIRM
    |-> o_program_supply_en)
    else $error("confirm without program supply");
endmodule
bind flash_host_ctrl flash_host_ctrl_asserts u_chk (.i_clk_sys, .i_rstn, .i_psel, .i_penable,
  .o_pready, .o_flash_ce_n, .o_flash_we_n, .o_flash_oe_n, .o_flash_addr, .o_flash_dq,
  .o_flash_dq_oe, .o_program_supply_en);

// *** verif/flash_dev_model.sv ***
// Purpose: behavioural parallel flash with command logic and status register
// Assumes: word mode, sixteen words of array
// Notes: busy lasts two status reads, so polling is exercised
`timescale 1ns/1ps
module flash_dev_model
  import flash_host_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h5A, // arbitrary value
  parameter logic [7:0] PART_CODE = 8'hC3 // arbitrary value
)
(
  // strobes and address
  input wire logic i_ce_n,
  input wire logic i_we_n,
  input wire logic i_oe_n,
  input wire logic [18:0] i_addr,
  // data and control
  input wire logic [15:0] i_dq,
  input wire logic i_supply_en,
  input wire logic i_no_supply,
  input wire logic i_reset_powerdown_n,
  output logic [15:0] o_dq
);
  logic [15:0] mem [0:15];
  logic [15:0] rd = 16'h0000;
  logic [7:0] sr = 8'h80;
  logic [1:0] pend = 2'h0;
  logic susp = 1'b0;
  int busy = 0;
  flash_mode_type mode = MODE_ARRAY;
  wire logic wr_edge = i_we_n | i_ce_n;
  wire logic sup = i_supply_en & ~i_no_supply;
  initial foreach (mem[i]) mem[i] = 16'hFFFF;
  // released bus shows the inverse, so a stale sample cannot pass
  assign o_dq = (!i_ce_n && !i_oe_n) ? rd : ~rd;
  always @(posedge wr_edge or negedge i_oe_n or negedge i_reset_powerdown_n) begin
    if (!i_reset_powerdown_n) begin
      sr <= 8'h80;
      mode <= MODE_ARRAY;
      pend <= 2'h0;
      susp <= 1'b0;
      busy <= 0;
    end else if (!i_oe_n) begin
      // latched at the falling edge only
      rd <= (mode == MODE_STATUS) ? {8'h00, sr} : (mode == MODE_ID) ?
        {8'h00, i_addr[0] ? PART_CODE : MAKER_CODE} : mem[i_addr[3:0]];
      if (busy > 0 && !susp) begin
        busy <= busy - 1;
        if (busy == 1) sr <= sr | 8'h80;
      end
    end else if (pend == 2'h1) begin
      mem[i_addr[3:0]] <= mem[i_addr[3:0]] & i_dq;
      sr <= {1'b0, sr[6:4], sr[3] | ~sup, 3'h0};
      busy <= 2;
      pend <= 2'h0;
      mode <= MODE_STATUS;
    end else if (pend == 2'h2) begin
      pend <= 2'h0;
      mode <= MODE_STATUS;
      if (i_dq[7:0] == CMD_CONFIRM) begin
        foreach (mem[i]) mem[i] <= 16'hFFFF;
        sr <= {1'b0, sr[6:4], sr[3] | ~sup, 3'h0};
        busy <= 2;
      end else sr <= sr | 8'h30;
    end else if (busy > 0 && !susp) begin
      // all but suspend ignored while busy
      if (i_dq[7:0] == CMD_SUSPEND) begin
        susp <= 1'b1;
        sr <= sr | 8'hC0;
      end
    end else begin
      case (i_dq[7:0])
        CMD_READ_ARRAY: mode <= MODE_ARRAY;
        CMD_READ_ID: mode <= MODE_ID;
        CMD_READ_STATUS: mode <= MODE_STATUS;
        CMD_CLEAR_STATUS: sr <= sr & ~SR_ERROR_MASK;
        CMD_ERASE_SETUP, CMD_PROG_SETUP, 8'h10: begin
          if (!sr[3] && !susp) pend <= (i_dq[7:0] == CMD_ERASE_SETUP) ? 2'h2 : 2'h1;
        end
        CMD_CONFIRM: begin
          if (susp) begin
            susp <= 1'b0;
            sr <= sr & 8'h3F;
            busy <= 2;
            mode <= MODE_STATUS;
          end
        end
        default: ;
      endcase
    end
  end
endmodule

// *** verif/test_flash_host_ctrl.sv ***
// Purpose: register level regression of the flash host controller
// Assumes: apb master holds each request until ready
// Notes: flash side is a behavioural model
`timescale 1ns/1ps
module test_flash_host_ctrl
  import flash_host_pkg::*;
;
  localparam logic [7:0] MAKER = 8'h5A; // arbitrary value
  localparam logic [7:0] PART = 8'hC3; // arbitrary value
  logic i_clk_sys, i_rstn, psel, penable, pwrite, pready, pslverr, no_supply;
  logic ce_n, we_n, oe_n, wsel_n, sup_en, wp_n, rp_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [18:0] faddr;
  logic [15:0] fdq, fdq_oe, dev_dq, bus_dq;
  logic [15:0] pv [2] = '{16'hA5F0, 16'h0FFF};
  logic [15:0] pe [2] = '{16'hA5F0, 16'h05F0};
  int err_total, tests_run;
  assign bus_dq = (fdq & fdq_oe) | (dev_dq & ~fdq_oe);
  flash_host_ctrl DUT (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_clk_en(1'b1),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_flash_ce_n(ce_n), .o_flash_we_n(we_n), .o_flash_oe_n(oe_n), .o_flash_addr(faddr),
    .o_flash_dq(fdq), .o_flash_dq_oe(fdq_oe), .i_flash_dq(bus_dq), .o_width_select_n(wsel_n),
    .o_program_supply_en(sup_en), .o_write_protect_n(wp_n), .o_reset_powerdown_n(rp_n));
  flash_dev_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) dev (.i_ce_n(ce_n), .i_we_n(we_n),
    .i_oe_n(oe_n), .i_addr(faddr), .i_dq(bus_dq), .i_supply_en(sup_en),
    .i_no_supply(no_supply), .i_reset_powerdown_n(rp_n), .o_dq(dev_dq));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk_sys);
    penable <= 1'b1;
    // ready, read data and the write all meet at one rising edge
    do @(posedge i_clk_sys); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk(q & m, e);
  endtask
  task automatic op(input logic [31:0] c);
    xfer(1'b1, REG_CMD, c);
    do xfer(1'b0, REG_STATUS, 32'h0000_0000); while (q[STAT_BUSY_BIT] !== 1'b0);
  endtask
  task stop_test;
    $display("tests_run %0d err_total %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end
  // whole run is several microseconds
  initial begin
    #400000;
    err_total++;
    $display("Error at %0t: watchdog expired", $time);
    stop_test;
  end
  initial begin
    {i_rstn, psel, penable, pwrite, paddr, pwdata, no_supply} = '0;
    err_total = 0;
    tests_run = 0;
    repeat (4) @(posedge i_clk_sys);
    chk({28'h0, wsel_n, wp_n, rp_n, ce_n}, 32'h0000_000B);
    i_rstn <= 1'b1;
    rd_chk(REG_STATUS, 32'h0000_3000, 32'h0000_0000);
    rd_chk(REG_CONFIG, 32'h0000_0007, {29'h0, CFG_RESET});
    rd_chk(12'h020, 32'hFFFF_FFFF, 32'h0000_0000);
    chk({31'h0, pslverr}, 32'h0000_0001);
    $display("test reset done");
    for (int i = 0; i < 2; i++) begin
      xfer(1'b1, REG_ADDR, i);
      op(OP_READ_ID);
      rd_chk(REG_RDATA, 32'h0000_FFFF, {24'h0, i ? PART : MAKER});
    end
    xfer(1'b1, REG_ADDR, 32'h0000_0003);
    op(OP_READ_DATA);
    rd_chk(REG_RDATA, 32'h0000_FFFF, 32'h0000_FFFF);
    $display("test identify done");
    for (int i = 0; i < 2; i++) begin
      xfer(1'b1, REG_WDATA, {16'h0, pv[i]});
      op(OP_PROGRAM);
      rd_chk(REG_STATUS, 32'h0000_00FF, 32'h0000_0080);
      op(OP_READ_DATA);
      rd_chk(REG_RDATA, 32'h0000_FFFF, {16'h0, pe[i]});
    end
    op(OP_ERASE);
    op(OP_READ_DATA);
    rd_chk(REG_RDATA, 32'h0000_FFFF, 32'h0000_FFFF);
    $display("test program erase done");
    no_supply <= 1'b1;
    op(OP_PROGRAM);
    rd_chk(REG_STATUS, 32'h0000_08FF, 32'h0000_0888);
    op(OP_PROGRAM);
    rd_chk(REG_STATUS, 32'h0000_0400, 32'h0000_0400);
    no_supply <= 1'b0;
    xfer(1'b1, REG_STATUS, 32'h0000_0400);
    op(OP_CLEAR_STATUS);
    rd_chk(REG_STATUS, 32'h0000_0CFF, 32'h0000_0080);
    $display("test supply done");
    op(OP_ERASE | 32'h0000_0010);
    op(OP_SUSPEND);
    rd_chk(REG_STATUS, 32'h0000_02FF, 32'h0000_02C0);
    op(OP_ERASE);
    rd_chk(REG_STATUS, 32'h0000_0400, 32'h0000_0400);
    xfer(1'b1, REG_STATUS, 32'h0000_0400);
    op(OP_RESUME);
    rd_chk(REG_STATUS, 32'h0000_06FF, 32'h0000_0080);
    $display("test suspend done");
    op(32'h0000_0009);
    rd_chk(REG_STATUS, 32'h0000_0400, 32'h0000_0400);
    xfer(1'b1, REG_CONFIG, 32'h0000_0006);
    @(posedge i_clk_sys);
    chk({29'h0, wsel_n, wp_n, rp_n}, 32'h0000_0002);
    $display("test refusal done");
    stop_test;
  end
endmodule
